// *** core/wd_pkg.sv ***
// Constants shared by the watchdog and reset status block
package wd_pkg;

	// Bus geometry
	localparam int          WB_DAT_W       = 32;
	localparam int          WB_ADR_W       = 8;
	localparam int          REG_W          = 8;

	// Register indices; the byte address is four times the index
	localparam logic [7:0]  REG_IDX_CAUSE  = 8'h20;
	localparam logic [7:0]  REG_IDX_CTRL   = 8'h21;
	localparam logic [1:0]  ADR_LOW_ZERO   = 2'h0;

	// Reset cause register fields
	localparam int          CAUSE_POR_BIT  = 0;
	localparam int          CAUSE_EXT_BIT  = 1;
	localparam int          CAUSE_BOR_BIT  = 2;
	localparam int          CAUSE_WD_BIT   = 3;
	localparam int          CAUSE_FLAGS_W  = 4;

	// Control register fields
	localparam int          CTRL_PS0_BIT   = 0;
	localparam int          CTRL_PS2_BIT   = 2;
	localparam int          CTRL_EN_BIT    = 3;
	localparam int          CTRL_UNLK_BIT  = 4;
	localparam int          CTRL_PS3_BIT   = 5;
	localparam int          CTRL_IE_BIT    = 6;
	localparam int          CTRL_IF_BIT    = 7;

	// Period select: codes above the last valid one are reserved
	localparam int          PERIOD_W       = 4;
	localparam logic [3:0]  PERIOD_RST     = 4'h0;
	localparam logic [3:0]  PERIOD_MAX     = 4'h9;
	localparam int          WD_BASE_CYCLES = 2048;
	localparam int          WD_CNT_W       = 21;

	// Clocks and the unlock window
	localparam int          CLK_HZ         = 50000000;
	localparam int          WD_OSC_HZ      = 128000;
	localparam int          UNLOCK_CYCLES  = 4;
	localparam int          UNLOCK_CNT_W   = 3;

	// Unlock window states, Gray coded
	typedef enum logic [1:0]
	{
		UL_IDLE = 2'b00,
		UL_OPEN = 2'b01
	} unlock_e;

endpackage

// *** core/wd_pin_sync.sv ***
// Two-flop synchronisers for the reset-source and fuse pins plus oscillator edge detect
`timescale 1ns/1ps
`default_nettype none
module wd_pin_sync
(
	input  wire logic clk,          // System clock
	input  wire logic osc_in,       // 128 kHz watchdog oscillator
	input  wire logic por_in,       // Power-on reset active
	input  wire logic bor_in,       // Brown-out reset active
	input  wire logic ext_in,       // External pin reset active
	input  wire logic level2_in,    // Safety level 2 fuse
	output logic      osc_tick,     // One-cycle pulse per oscillator rise
	output logic      por_s,        // Synchronised power-on
	output logic      bor_s,        // Synchronised brown-out
	output logic      ext_s,        // Synchronised external reset
	output logic      level2_s      // Synchronised fuse level
);

	logic [4:0] meta_q;
	logic [4:0] sync_q;
	logic       osc_last_q;

	////////////////////////////////////////////////////////////////////////////////
	// No reset here: the cause pins must be seen while the chip sits in reset
	always_ff @(posedge clk)
	begin
		meta_q <= {level2_in, ext_in, bor_in, por_in, osc_in};
		sync_q <= meta_q;
		osc_last_q <= sync_q[0];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Edge detect reads the second stage and its delayed copy, never the first
	assign osc_tick = sync_q[0] & ~osc_last_q;
	assign por_s    = sync_q[1];
	assign bor_s    = sync_q[2];
	assign ext_s    = sync_q[3];
	assign level2_s = sync_q[4];

endmodule
`default_nettype wire

// *** core/wd_reset_status.sv ***
// Watchdog timer control and reset cause status behind a Wishbone slave
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module wd_reset_status
	import wd_pkg::*;
#(
	parameter int WD_BASE = WD_BASE_CYCLES     // Oscillator cycles of the shortest period
)
(
	input  wire logic                clk,               // System clock, 50 MHz
	input  wire logic                rst,               // Chip reset, synchronous, active high
	input  wire logic                wb_cyc_i,          // Wishbone cycle
	input  wire logic                wb_stb_i,          // Wishbone strobe
	input  wire logic                wb_we_i,           // Wishbone write enable
	input  wire logic [WB_ADR_W-1:0] wb_adr_i,          // Wishbone byte address
	input  wire logic [3:0]          wb_sel_i,          // Wishbone byte selects
	input  wire logic [WB_DAT_W-1:0] wb_dat_i,          // Wishbone write data
	output logic      [WB_DAT_W-1:0] wb_dat_o,          // Wishbone read data
	output logic                     wb_ack_o,          // Wishbone acknowledge
	input  wire logic                wd_osc_in,         // 128 kHz watchdog oscillator pin
	input  wire logic                por_active,        // Power-on reset source active
	input  wire logic                bor_active,        // Brown-out reset source active
	input  wire logic                ext_active,        // External pin reset source active
	input  wire logic                safety_level2,     // Fuse: safety level 2 when high
	input  wire logic                wd_restart_instr,  // Restart instruction pulse from core
	input  wire logic                global_irq_enable, // Global interrupt enable from core
	input  wire logic                wd_irq_vector_ack, // Core executes the watchdog vector
	output logic                     wd_irq_req,        // Watchdog interrupt request
	output logic                     wd_chip_reset      // One-cycle watchdog reset request
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	logic                    osc_tick;
	logic                    por_s;
	logic                    bor_s;
	logic                    ext_s;
	logic                    level2_s;

	logic [CAUSE_FLAGS_W-1:0] cause_q;
	logic                    irq_flag_q;
	logic                    irq_en_q;
	logic                    en_q;
	logic [PERIOD_W-1:0]     period_q;
	unlock_e                 unlock_q;
	logic [UNLOCK_CNT_W-1:0] unlock_cnt_q;
	logic [WD_CNT_W-1:0]     wd_cnt_q;
	logic                    reset_pulse_q;
	logic                    ack_q;
	logic [WB_DAT_W-1:0]     rdata_q;

	logic                    bus_req;
	logic                    wr_take;
	logic                    wr_cause;
	logic                    wr_ctrl;
	logic [REG_W-1:0]        wdat;
	logic                    unlocked;
	logic                    en_eff;
	logic                    running;
	logic [WD_CNT_W-1:0]     limit;
	logic                    timeout;
	logic [REG_W-1:0]        ctrl_view;
	logic [REG_W-1:0]        cause_view;
	logic                    unlock_open;

	////////////////////////////////////////////////////////////////////////////////
	// Address decode, shared by reads and writes

	function automatic logic hits(input logic [WB_ADR_W-1:0] adr, input logic [7:0] idx);
		logic [WB_ADR_W-1:0] word;
		word = {idx[WB_ADR_W-3:0], ADR_LOW_ZERO};
		return adr == word;
	endfunction

	// Period code to oscillator cycles; reserved codes take the longest period
	function automatic logic [WD_CNT_W-1:0] period_cycles(input logic [PERIOD_W-1:0] code);
		logic [PERIOD_W-1:0] c;
		c = (code > PERIOD_MAX) ? PERIOD_MAX : code;
		return WD_CNT_W'(WD_BASE) << c;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	// The cause pins and the fuse are asynchronous; only synced copies are read

	wd_pin_sync u_sync
	(
		.clk       (clk),
		.osc_in    (wd_osc_in),
		.por_in    (por_active),
		.bor_in    (bor_active),
		.ext_in    (ext_active),
		.level2_in (safety_level2),
		.osc_tick  (osc_tick),
		.por_s     (por_s),
		.bor_s     (bor_s),
		.ext_s     (ext_s),
		.level2_s  (level2_s)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Bus slave: ack one cycle after the request, writes land on the ack edge
	// A request is taken on an edge with cyc and stb high and ack low; ack
	// then stands for one cycle and the write lands on the edge that samples
	// it. The read path is registered, so every access costs two edges.

	assign bus_req  = wb_cyc_i & wb_stb_i;
	assign wr_take  = bus_req & wb_we_i & ack_q & wb_sel_i[0];
	assign wr_cause = wr_take & hits(wb_adr_i, REG_IDX_CAUSE);
	assign wr_ctrl  = wr_take & hits(wb_adr_i, REG_IDX_CTRL);
	assign wdat     = wb_dat_i[REG_W-1:0];

	// Acknowledge every access, mapped or not, so the bus never hangs
	always_ff @(posedge clk)
	begin
		if (rst)
			ack_q <= 1'b0;
		else
			ack_q <= bus_req & ~ack_q;
	end

	// Read data captured with the request; unmapped addresses read zero
	always_ff @(posedge clk)
	begin
		if (rst)
			rdata_q <= '0;
		else if (bus_req & ~ack_q)
		begin
			if (hits(wb_adr_i, REG_IDX_CAUSE))
				rdata_q <= {{(WB_DAT_W-REG_W){1'b0}}, cause_view};
			else if (hits(wb_adr_i, REG_IDX_CTRL))
				rdata_q <= {{(WB_DAT_W-REG_W){1'b0}}, ctrl_view};
			else
				rdata_q <= '0;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdata_q;

	////////////////////////////////////////////////////////////////////////////////
	// Reset cause flags: not cleared by the chip reset, so they survive it

	// Upper nibble is not stored at all, so it reads zero whatever was written
	assign cause_view = {{(REG_W-CAUSE_FLAGS_W){1'b0}}, cause_q};

	// Power-on both clears the other causes and records itself; the chip
	// reset is not applied here, so a recorded cause outlives its own reset
	// Hardware sets win over a software zero-write in the same cycle
	always_ff @(posedge clk)
	begin
		if (por_s)
		begin
			cause_q                <= '0;
			cause_q[CAUSE_POR_BIT] <= 1'b1;
		end
		else
		begin
			if (wr_cause)
				cause_q <= cause_q & wdat[CAUSE_FLAGS_W-1:0];
			if (reset_pulse_q)
				cause_q[CAUSE_WD_BIT] <= 1'b1;
			if (bor_s)
				cause_q[CAUSE_BOR_BIT] <= 1'b1;
			if (ext_s)
				cause_q[CAUSE_EXT_BIT] <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Unlock window: opened by one write carrying unlock and enable

	assign unlocked = (unlock_q == UL_OPEN);

	// Only a write carrying both unlock and enable opens the window
	assign unlock_open = wr_ctrl & wdat[CTRL_UNLK_BIT] & wdat[CTRL_EN_BIT];

	// Counted in system clocks; a fresh open write restarts the count
	// The count runs down to zero, so the window covers the four edges after the open
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			unlock_q     <= UL_IDLE;
			unlock_cnt_q <= '0;
		end
		else if (unlock_open)
		begin
			unlock_q     <= UL_OPEN;
			unlock_cnt_q <= UNLOCK_CNT_W'(UNLOCK_CYCLES - 1);
		end
		else
		begin
			case (unlock_q)
				UL_IDLE:
					unlock_cnt_q <= '0;
				UL_OPEN:
				begin
					if (unlock_cnt_q == '0)
						unlock_q <= UL_IDLE;
					else
						unlock_cnt_q <= unlock_cnt_q - 1'b1;
				end
				default:
					unlock_q <= UL_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Enable bit and period select

	// Level 2 pins the enable; level 1 forces it while the watchdog flag stands
	assign en_eff = en_q | level2_s | cause_q[CAUSE_WD_BIT];

	// A zero only sticks inside the window; a one always sticks
	// Level 2 and the flag force only en_eff, not en_q, so the stored bit can still clear
	always_ff @(posedge clk)
	begin
		if (rst)
			en_q <= 1'b0;
		else if (wr_ctrl)
		begin
			if (wdat[CTRL_EN_BIT])
				en_q <= 1'b1;
			else if (unlocked)
				en_q <= 1'b0;
		end
	end

	// Judged on the window state before this write, so it cannot self-unlock
	always_ff @(posedge clk)
	begin
		if (rst)
			period_q <= PERIOD_RST;
		else if (wr_ctrl & unlocked)
			period_q <= {wdat[CTRL_PS3_BIT], wdat[CTRL_PS2_BIT:CTRL_PS0_BIT]};
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt enable and flag

	// A timeout with the enable set arms the next timeout for a reset
	always_ff @(posedge clk)
	begin
		if (rst)
			irq_en_q <= 1'b0;
		else if (timeout & en_eff)
			irq_en_q <= 1'b0;
		else if (wr_ctrl)
			irq_en_q <= wdat[CTRL_IE_BIT];
	end

	// Set wins over the write-one clear and over the vector clear,
	// so a timeout that lands on a clear is never lost
	always_ff @(posedge clk)
	begin
		if (rst)
			irq_flag_q <= 1'b0;
		else if (timeout & irq_en_q)
			irq_flag_q <= 1'b1;
		else if (wd_irq_vector_ack | (wr_ctrl & wdat[CTRL_IF_BIT]))
			irq_flag_q <= 1'b0;
	end

	assign wd_irq_req = irq_flag_q & irq_en_q & global_irq_enable;

	////////////////////////////////////////////////////////////////////////////////
	// Timeout counter on the oscillator tick
	// Limitation: the period is read live, so a change in the window applies
	// to the count already under way rather than waiting for a restart

	assign running = en_eff | irq_en_q;
	assign limit   = period_cycles(period_q);
	// Greater-or-equal, so a period shortened mid-count ends on the next tick
	// instead of letting the counter run through its whole range first
	assign timeout = running & osc_tick & (wd_cnt_q >= limit - 1'b1);

	// Stopped timer holds at zero so enabling it starts a full period
	always_ff @(posedge clk)
	begin
		if (rst | wd_restart_instr | ~running)
			wd_cnt_q <= '0;
		else if (timeout)
			wd_cnt_q <= '0;
		else if (osc_tick)
			wd_cnt_q <= wd_cnt_q + 1'b1;
	end

	// Reset only when enable is set and interrupt enable is clear
	always_ff @(posedge clk)
	begin
		if (rst)
			reset_pulse_q <= 1'b0;
		else
			reset_pulse_q <= timeout & en_eff & ~irq_en_q;
	end

	assign wd_chip_reset = reset_pulse_q;

	////////////////////////////////////////////////////////////////////////////////
	// Control register read view
	// Enable reads back the forced value, not only the stored bit

	always_comb
	begin
		ctrl_view                                = '0;
		ctrl_view[CTRL_IF_BIT]                   = irq_flag_q;
		ctrl_view[CTRL_IE_BIT]                   = irq_en_q;
		ctrl_view[CTRL_PS3_BIT]                  = period_q[PERIOD_W-1];
		ctrl_view[CTRL_UNLK_BIT]                 = unlocked;
		ctrl_view[CTRL_EN_BIT]                   = en_eff;
		ctrl_view[CTRL_PS2_BIT:CTRL_PS0_BIT]     = period_q[PERIOD_W-2:0];
	end

endmodule
`default_nettype wire

// *** dv/wd_reset_status_props.sv ***
// Concurrent checks on the ports of the watchdog and reset status block
`timescale 1ns/1ps
`default_nettype none
module wd_reset_status_props
	import wd_pkg::*;
#(
	parameter int WD_BASE = WD_BASE_CYCLES  // Shortest period, kept for the bind
)
(
	input wire logic                clk,               // System clock
	input wire logic                rst,               // Chip reset
	input wire logic                wb_cyc_i,          // Bus cycle
	input wire logic                wb_stb_i,          // Bus strobe
	input wire logic                wb_we_i,           // Bus write
	input wire logic [WB_ADR_W-1:0] wb_adr_i,          // Bus address
	input wire logic [WB_DAT_W-1:0] wb_dat_o,          // Read data
	input wire logic                wb_ack_o,          // Acknowledge
	input wire logic                safety_level2,     // Level 2 fuse
	input wire logic                global_irq_enable, // Core interrupt enable
	input wire logic                wd_irq_req,        // Interrupt request
	input wire logic                wd_chip_reset      // Watchdog reset pulse
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// A fresh read request; data is judged in the ack cycle that follows
	logic rd_req;
	assign rd_req = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

	////////////////////////////////////////////////////////////////
	a_ack_one_shot: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held for more than one cycle");
	a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acknowledged in the next cycle");
	a_read_upper_zero: assert property (rd_req |=> wb_dat_o[31:8] == 24'h000000)
		else $error("read data above the register width not zero");
	a_cause_high_zero: assert property (rd_req && wb_adr_i == 8'h80 |=> wb_dat_o[7:4] == 4'h0)
		else $error("cause register upper bits not zero");
	a_unmapped_zero: assert property (rd_req && wb_adr_i != 8'h80 && wb_adr_i != 8'h84 |=> wb_dat_o == 32'h0)
		else $error("unmapped read returned data");
	a_irq_gate: assert property (wd_irq_req |-> global_irq_enable)
		else $error("interrupt requested while globally disabled");
	a_reset_one_cycle: assert property (wd_chip_reset |=> !wd_chip_reset)
		else $error("watchdog reset pulse longer than one cycle");
	a_level2_enabled: assert property (safety_level2 [*4] ##0 (rd_req && wb_adr_i == 8'h84) |=> wb_dat_o[3])
		else $error("enable reads zero in safety level 2");
endmodule

bind wd_reset_status wd_reset_status_props #(.WD_BASE(WD_BASE)) props_i (.clk(clk), .rst(rst),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .safety_level2(safety_level2), .global_irq_enable(global_irq_enable),
	.wd_irq_req(wd_irq_req), .wd_chip_reset(wd_chip_reset));
`default_nettype wire

// *** dv/tb_wd_reset_status.sv ***
// Self-checking bench for the watchdog and reset status block
`timescale 1ns/1ps
`default_nettype none
module tb_wd_reset_status
	import wd_pkg::*;
;
	localparam logic [7:0] CAUSE = {REG_IDX_CAUSE[5:0], ADR_LOW_ZERO};
	localparam logic [7:0] CTRL  = {REG_IDX_CTRL[5:0], ADR_LOW_ZERO};
	logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, osc = 1'b0;
	logic        por = 1'b1, bor = 1'b0, ext = 1'b0, lvl2 = 1'b0, rsti = 1'b0, gie = 1'b0, vack = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dat = 32'h00000000;
	logic [31:0] expq[$];
	wire logic [31:0] rdat;
	wire logic   ack, irq, wdrst;
	integer      seed = 32'h0CCC02EE;
	int          mismatches = 0, checked = 0, resets = 0;

	// Short base period keeps a time-out to two oscillator ticks at period code 0, four at code 1
	wd_reset_status #(.WD_BASE(2)) dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .wd_osc_in(osc),
		.por_active(por), .bor_active(bor), .ext_active(ext), .safety_level2(lvl2), .wd_restart_instr(rsti),
		.global_irq_enable(gie), .wd_irq_vector_ack(vack), .wd_irq_req(irq), .wd_chip_reset(wdrst));

	always #10 clk = ~clk;

	////////////////////////////////////////////////////////////////
	task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t read %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t output %b expected %b", $time, got, exp);
		end
	endtask

	// One classic cycle; junk in the unused data bits must be ignored
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
		int n;
		logic [31:0] r;
		r = $random(seed);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {r[23:0], d};
		if (!w)
			expq.push_back({24'h000000, e});
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end while (!ack && n < 20);
		cmp_bit(ack, 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	// Each tick sits long enough for the pin synchroniser to see it
	task automatic ticks(input int k);
		repeat (k)
		begin
			@(posedge clk);
			osc <= 1'b1;
			repeat (3) @(posedge clk);
			osc <= 1'b0;
			repeat (3) @(posedge clk);
		end
		repeat (4) @(posedge clk);
	endtask

	task automatic close_out;
		if (expq.size() != 0)
			mismatches++;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Watcher: pops the oldest expected read at each read ack, counts reset pulses
	always @(posedge clk)
	begin
		if (ack && !we)
		begin
			if (expq.size() == 0)
			begin
				mismatches++;
				$display("[ERR] %0t read acknowledged with nothing expected", $time);
			end
			else
				cmp_rd(rdat, expq.pop_front());
		end
		if (wdrst)
			resets++;
	end

	// Hang guard, far beyond the few hundred cycles the sequence needs
	initial
	begin
		repeat (5000) @(posedge clk);
		mismatches++;
		close_out();
	end

	initial
	begin
		repeat (8) @(posedge clk);
		por <= 1'b0;
		rst <= 1'b0;
		bus(0, CAUSE, 8'h00, 8'h01);
		ext <= 1'b1;
		repeat (5) @(posedge clk);
		ext <= 1'b0;
		bor <= 1'b1;
		repeat (5) @(posedge clk);
		bor <= 1'b0;
		repeat (4) @(posedge clk);
		bus(0, CAUSE, 8'h00, 8'h07);
		bus(1, CAUSE, 8'hFB, 8'h00);
		bus(0, CAUSE, 8'h00, 8'h03);
		bus(1, CAUSE, 8'h00, 8'h00);
		bus(0, CAUSE, 8'h00, 8'h00);
		bus(0, 8'h10, 8'h00, 8'h00);
		bus(1, CTRL, 8'h08, 8'h00);
		bus(1, CTRL, 8'h21, 8'h00);
		bus(0, CTRL, 8'h00, 8'h08);
		bus(1, CTRL, 8'h18, 8'h00);
		bus(1, CTRL, 8'h21, 8'h00);
		bus(0, CTRL, 8'h00, 8'h21);
		bus(1, CTRL, 8'h08, 8'h00);
		bus(1, CTRL, 8'h39, 8'h00);
		repeat (6) @(posedge clk);
		bus(1, CTRL, 8'h00, 8'h00);
		bus(0, CTRL, 8'h00, 8'h29);
		bus(1, CTRL, 8'h18, 8'h00);
		bus(1, CTRL, 8'h00, 8'h00);
		bus(0, CTRL, 8'h00, 8'h00);
		gie <= 1'b1;
		bus(1, CTRL, 8'h40, 8'h00);
		ticks(2);
		cmp_bit(irq, 1'b1);
		bus(0, CTRL, 8'h00, 8'hC0);
		gie <= 1'b0;
		@(posedge clk);
		cmp_bit(irq, 1'b0);
		gie <= 1'b1;
		vack <= 1'b1;
		@(posedge clk);
		vack <= 1'b0;
		repeat (2) @(posedge clk);
		cmp_bit(irq, 1'b0);
		ticks(2);
		bus(0, CTRL, 8'h00, 8'hC0);
		bus(1, CTRL, 8'hC0, 8'h00);
		bus(0, CTRL, 8'h00, 8'h40);
		rsti <= 1'b1;
		@(posedge clk);
		rsti <= 1'b0;
		bus(1, CTRL, 8'h48, 8'h00);
		ticks(2);
		bus(0, CTRL, 8'h00, 8'h88);
		bus(1, CTRL, 8'h98, 8'h00);
		bus(1, CTRL, 8'h09, 8'h00);
		ticks(1);
		rsti <= 1'b1;
		@(posedge clk);
		rsti <= 1'b0;
		ticks(3);
		cmp_bit(resets == 0, 1'b1);
		ticks(1);
		cmp_bit(resets == 1, 1'b1);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		bus(0, CAUSE, 8'h00, 8'h08);
		bus(0, CTRL, 8'h00, 8'h08);
		bus(1, CTRL, 8'h18, 8'h00);
		bus(1, CTRL, 8'h00, 8'h00);
		bus(0, CTRL, 8'h00, 8'h08);
		bus(1, CAUSE, 8'h00, 8'h00);
		bus(0, CTRL, 8'h00, 8'h00);
		bus(1, CTRL, 8'h08, 8'h00);
		bus(1, CTRL, 8'h18, 8'h00);
		bus(1, CTRL, 8'h00, 8'h00);
		bus(0, CTRL, 8'h00, 8'h00);
		lvl2 <= 1'b1;
		repeat (5) @(posedge clk);
		bus(1, CTRL, 8'h18, 8'h00);
		bus(1, CTRL, 8'h00, 8'h00);
		bus(0, CTRL, 8'h00, 8'h08);
		repeat (2) @(posedge clk);
		close_out();
	end
endmodule
`default_nettype wire
